/* nfc_bus_cycle.sv */
// One asynchronous x8 bus cycle, write or read, timed in core clocks.
// Assumes the flash data pins are already synchronised by the caller.
`default_nettype none
module nfc_bus_cycle (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Cycle request
  input wire logic start,
  input wire nfc_pkg::nfc_cyc_t cyc,
  output logic busy,
  output logic done,
  output logic [7:0] rd_data,
  // Flash pins
  input wire logic [7:0] dq_in_sync,
  output nfc_pkg::nfc_pins_t pins
);
  typedef enum logic [1:0] {NFC_BC_IDLE, NFC_BC_SETUP, NFC_BC_PULSE,
    NFC_BC_HOLD} nfc_bc_state_t;
  typedef struct packed {
    nfc_bc_state_t st;
    logic [3:0] cnt;
    nfc_pkg::nfc_cyc_t cyc;
    logic done;
    logic [7:0] rd;
    nfc_pkg::nfc_pins_t pins;
  } nfc_bc_t;

  nfc_bc_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      NFC_BC_IDLE: begin
        if (start) begin
          s_d.cyc = cyc;
          s_d.st = NFC_BC_SETUP;
          s_d.cnt = nfc_pkg::SETUP_CYC;
          s_d.pins.addr = cyc.addr;
          s_d.pins.dq_out = cyc.data;
          s_d.pins.dq_oe = !cyc.is_read;
          s_d.pins.ce_n = 1'b0;
        end
      end
      NFC_BC_SETUP: begin
        if (s_q.cnt <= 4'h1) begin
          s_d.st = NFC_BC_PULSE;
          // Without the lag the sample would see the bus before the strobe
          s_d.cnt = s_q.cyc.is_read ?
            4'(nfc_pkg::RD_CYC + nfc_pkg::RD_LAG_CYC) : nfc_pkg::PULSE_CYC;
          s_d.pins.we_n = s_q.cyc.is_read;
          s_d.pins.oe_n = !s_q.cyc.is_read;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      NFC_BC_PULSE: begin
        if (s_q.cnt <= 4'h1) begin
          // Data sampled before OE# rises so the bus is still driven
          if (s_q.cyc.is_read) s_d.rd = dq_in_sync;
          s_d.pins.we_n = 1'b1;
          s_d.pins.oe_n = 1'b1;
          s_d.st = NFC_BC_HOLD;
          s_d.cnt = nfc_pkg::SETUP_CYC;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      NFC_BC_HOLD: begin
        if (s_q.cnt <= 4'h1) begin
          s_d.pins.ce_n = 1'b1;
          s_d.pins.dq_oe = 1'b0;
          s_d.st = NFC_BC_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: NFC_BC_IDLE, cnt: 4'h0, cyc: '0, done: 1'b0, rd: 8'h00,
        pins: '{addr: '0, dq_out: 8'h00, dq_oe: 1'b0, ce_n: 1'b1,
        we_n: 1'b1, oe_n: 1'b1}};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = (s_q.st != NFC_BC_IDLE);
  assign done = s_q.done;
  assign rd_data = s_q.rd;
  assign pins = s_q.pins;
endmodule
`default_nettype wire

/* nfc_flash_model.sv */
// Behavioural x8 flash: logs write cycles, answers reads from the address.
// Assumes registered host pins sampled on the core clock.
`default_nettype none
module nfc_flash_model (
  // Clock
  input wire logic core_clk,
  // Flash pins
  input wire logic [nfc_pkg::AW-1:0] addr,
  input wire logic [7:0] dq,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  output logic [7:0] dq_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [29:0] wr_q[$];
  logic [nfc_pkg::AW-1:0] rd_addr = '0;
  logic we_q = 1'b1;
  logic oe_q = 1'b1;
  int rd_cnt = 0;
  int hold = 0;
  always @(posedge core_clk) begin
    we_q <= we_n;
    oe_q <= oe_n;
    // Whole address kept; the bench decides which bits matter
    if (!ce_n && we_n && !we_q)
      wr_q.push_back({addr, dq});
    if (!oe_n) begin
      rd_addr <= addr;
      hold <= 4;
    end else if (hold > 0)
      hold <= hold - 1;
    if (oe_n && !oe_q)
      rd_cnt <= rd_cnt + 1;
  end
  // Overlay, status, id and verify reads all answer from the address
  // Released bus shows the inverse so a stale sample cannot match
  assign dq_rd = (hold > 0) ? rd_addr[7:0] ^ 8'hA5 : ~(rd_addr[7:0] ^ 8'hA5);
endmodule
`default_nettype wire

/* nfc_host.sv */
// Host controller that issues x8 NOR flash command sequences on the pins.
// Assumes a single requester, one request at a time, and a flash that
// answers reads within the read pulse.
//
// Functional notes
// RL1 - 51 suspends, 50 resumes program, any address
// RL2 - Secure entry: AA/AAA, 55/555, 88/AAA
// RL3 - Secure overlay reads return secure contents
// RL4 - Secure word program: unlock, A0, data
// RL5 - Buffer program: unlock, 25, count, pairs, 29
// RL6 - Buffer sequence at most 261 cycles
// RL7 - Abort reset: AA, 55, F0 to AAA
// RL8 - Secure exit: unlock, 90/AAA, 00/any
// RL9 - F0 anywhere returns to read mode
// RL10 - Query 98 at AA; exit F0 or FF
// RL11 - Continuity check seven cycles with reads
// RL12 - ECC overlay entry: unlock then 75/AAA
// RL13 - ECC overlay reads return correction status
// RL14 - ECC overlay left by F0 anywhere
// RL15 - Upper address ignored on 555/AAA cycles
// RL16 - Address 21 to 11 don't care
// RL17 - Status byte half chosen by bit one
// RL18 - Autoselect fourth cycle read, ignore upper lanes
// RL19 - Device id needs three autoselect reads
// RL20 - Protect verify reads 00 or 01
// RL21 - Erase resume only while erase suspended
// RL22 - Erase suspend limits; suspend only sector erase
// RL23 - Load count is locations minus one
// RL24 - Buffer addresses stay in one page
// RL25 - Mismatched write abandons partial sequence
`default_nettype none
module nfc_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Command port
  input wire logic req_valid,
  input wire nfc_pkg::nfc_req_t req,
  output logic req_ready,
  // Buffer data stream, one address/data pair per beat
  input wire logic buf_valid,
  input wire logic [nfc_pkg::AW-1:0] buf_addr,
  input wire logic [7:0] buf_data,
  output logic buf_ready,
  // Read answers
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic seq_error,
  // Flash pins
  output logic [nfc_pkg::AW-1:0] flash_addr,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n
);
  typedef enum logic [2:0] {NFC_H_IDLE, NFC_H_ISSUE, NFC_H_WAIT,
    NFC_H_BUF, NFC_H_BUFWAIT, NFC_H_CONFIRM} nfc_h_state_t;
  typedef struct packed {
    nfc_h_state_t st;
    nfc_pkg::nfc_req_t req;
    logic [4:0] step;
    logic [4:0] len;
    logic [8:0] left;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
    logic rd_valid;
    logic [7:0] rd;
    logic err;
    logic ready;
    logic buf_ready;
    logic suspended;
    nfc_pkg::nfc_pins_t pins;
  } nfc_h_t;

  nfc_h_t s_q, s_d;
  logic bc_start, bc_busy, bc_done;
  logic [7:0] bc_rd;
  nfc_pkg::nfc_cyc_t bc_cyc;
  nfc_pkg::nfc_pins_t pins;

  // Sequence table: cycle number of the current request
  function automatic nfc_pkg::nfc_cyc_t seq_cyc(input nfc_pkg::nfc_req_t r,
                                                input logic [4:0] k);
    nfc_pkg::nfc_cyc_t c;
    c = '{is_read: 1'b0, addr: nfc_pkg::ADDR_AAA, data: nfc_pkg::D_UNLOCK1};
    if (k == 5'h01) begin
      c.addr = nfc_pkg::ADDR_555; // RL15
      c.data = nfc_pkg::D_UNLOCK2;
    end
    unique case (r.op)
      nfc_pkg::NFC_OP_SUSPEND: c = '{1'b0, r.addr, nfc_pkg::D_SUSPEND}; // RL1
      nfc_pkg::NFC_OP_RESUME: c = '{1'b0, r.addr, nfc_pkg::D_RESUME}; // RL1
      nfc_pkg::NFC_OP_SECURE_ENTER:
        if (k == 5'h02) c.data = nfc_pkg::D_SECURE_ENTRY; // RL2
      nfc_pkg::NFC_OP_SECURE_EXIT: begin
        if (k == 5'h02) c.data = nfc_pkg::D_EXIT1; // RL8
        if (k == 5'h03) c = '{1'b0, r.addr, nfc_pkg::D_ZERO}; // RL8
      end
      nfc_pkg::NFC_OP_WORD_PROG: begin
        if (k == 5'h02) c.data = nfc_pkg::D_PROGRAM; // RL4
        if (k == 5'h03) c = '{1'b0, r.addr, r.data}; // RL4
      end
      nfc_pkg::NFC_OP_BUF_PROG: begin
        if (k == 5'h02) c = '{1'b0, r.addr, nfc_pkg::D_BUF_LOAD}; // RL5
        if (k == 5'h03) c = '{1'b0, r.addr, r.data}; // RL23
      end
      nfc_pkg::NFC_OP_BUF_ABORT:
        if (k == 5'h02) c.data = nfc_pkg::D_RESET; // RL7
      nfc_pkg::NFC_OP_RESET: c = '{1'b0, r.addr, nfc_pkg::D_RESET}; // RL9 RL14
      nfc_pkg::NFC_OP_QUERY:
        c = '{1'b0, nfc_pkg::ADDR_AA, nfc_pkg::D_QUERY}; // RL10
      nfc_pkg::NFC_OP_QUERY_EXIT:
        c = '{1'b0, r.addr, nfc_pkg::D_RESET_ALT}; // RL10 RL16
      nfc_pkg::NFC_OP_CONTINUITY: begin
        unique case (k) // RL11
          5'h00: c = '{1'b0, nfc_pkg::ADDR_AAA, nfc_pkg::D_CONT1};
          5'h01: c = '{1'b0, nfc_pkg::ADDR_AAA, nfc_pkg::D_CONT2};
          5'h03: c = '{1'b0, nfc_pkg::ADDR_CONT4, nfc_pkg::D_RESET_ALT};
          5'h04: c = '{1'b0, nfc_pkg::ADDR_CONT5, nfc_pkg::D_ZERO};
          5'h05: c = '{1'b0, nfc_pkg::ADDR_AAA, nfc_pkg::D_CONT2};
          default: c = '{1'b1, nfc_pkg::ADDR_ZERO, nfc_pkg::D_ZERO};
        endcase
      end
      nfc_pkg::NFC_OP_ECC_ENTER:
        if (k == 5'h02) c.data = nfc_pkg::D_ECC_ENTRY; // RL12
      nfc_pkg::NFC_OP_READ:
        c = '{1'b1, r.addr, nfc_pkg::D_ZERO}; // RL3 RL13 RL20
      nfc_pkg::NFC_OP_STATUS_READ: // RL17
        c = '{1'b1, r.hi_half ? (r.addr | nfc_pkg::ADDR_BIT_ONE)
              : (r.addr & ~nfc_pkg::ADDR_BIT_ONE), nfc_pkg::D_ZERO};
      nfc_pkg::NFC_OP_AUTOSEL_ID: begin
        if (k == 5'h02) c.data = nfc_pkg::D_AUTOSEL;
        if (k >= 5'h03) c = '{1'b1, r.addr, nfc_pkg::D_ZERO}; // RL18
      end
      default: c = '{1'b1, r.addr, nfc_pkg::D_ZERO};
    endcase
    return c;
  endfunction

  function automatic logic [4:0] seq_len(input nfc_pkg::nfc_op_t op);
    unique case (op)
      nfc_pkg::NFC_OP_SECURE_ENTER, nfc_pkg::NFC_OP_BUF_ABORT,
      nfc_pkg::NFC_OP_ECC_ENTER: return 5'h03;
      nfc_pkg::NFC_OP_SECURE_EXIT, nfc_pkg::NFC_OP_WORD_PROG,
      nfc_pkg::NFC_OP_BUF_PROG: return 5'h04;
      nfc_pkg::NFC_OP_AUTOSEL_ID: return 5'h06; // RL19
      nfc_pkg::NFC_OP_CONTINUITY: return nfc_pkg::SEQ_LEN;
      default: return 5'h01;
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    s_d.dq_s1 = flash_dq_in;
    s_d.dq_s2 = s_q.dq_s1;
    s_d.pins = pins;
    bc_start = 1'b0;
    bc_cyc = seq_cyc(s_q.req, s_q.step);
    unique case (s_q.st)
      NFC_H_IDLE: begin
        if (!s_q.ready) begin
          // A refused request drops ready for one cycle only
          s_d.ready = 1'b1;
        end else if (req_valid) begin
          s_d.req = req;
          s_d.step = 5'h00;
          s_d.len = seq_len(req.op);
          s_d.err = 1'b0;
          s_d.ready = 1'b0;
          // Load count is locations minus one, so beats = count + 1
          s_d.left = {1'b0, req.data} + 9'h001; // RL6 RL23
          // Reads and programs stay allowed while suspended
          if (req.op == nfc_pkg::NFC_OP_SUSPEND) begin
            s_d.suspended = 1'b1; // RL22
          end
          if (req.op == nfc_pkg::NFC_OP_BUF_PROG &&
              req.data > nfc_pkg::MAX_LOAD_COUNT) begin
            s_d.err = 1'b1; // RL6
          end else if (req.op == nfc_pkg::NFC_OP_RESUME &&
                       !s_q.suspended) begin
            // Nothing suspended: the resume never reaches the bus
            s_d.err = 1'b1; // RL21
          end else begin
            if (req.op == nfc_pkg::NFC_OP_RESUME) begin
              s_d.suspended = 1'b0; // RL21
            end
            s_d.st = NFC_H_ISSUE;
          end
        end
      end
      NFC_H_ISSUE: begin
        bc_start = 1'b1;
        s_d.st = NFC_H_WAIT;
      end
      NFC_H_WAIT: begin
        if (bc_done) begin
          if (bc_cyc.is_read) begin
            // Upper lanes absent in x8, so only the byte is returned
            s_d.rd = bc_rd; // RL18
            s_d.rd_valid = 1'b1;
          end
          if (s_q.step + 5'h01 >= s_q.len) begin
            if (s_q.req.op == nfc_pkg::NFC_OP_BUF_PROG) begin
              s_d.st = NFC_H_BUF;
              s_d.buf_ready = 1'b1;
            end else begin
              s_d.st = NFC_H_IDLE;
              s_d.ready = 1'b1;
            end
          end else begin
            s_d.step = s_q.step + 5'h01;
            s_d.st = NFC_H_ISSUE;
          end
        end
      end
      NFC_H_BUF: begin
        if (buf_valid) begin
          s_d.buf_ready = 1'b0;
          // Page check: a pair outside the start page aborts the load
          if ((buf_addr >> nfc_pkg::PAGE_SHIFT) !=
              (s_q.req.addr >> nfc_pkg::PAGE_SHIFT)) begin // RL24
            s_d.err = 1'b1;
            s_d.req.op = nfc_pkg::NFC_OP_BUF_ABORT; // RL7 RL25
            s_d.step = 5'h00;
            s_d.len = 5'h03;
            s_d.st = NFC_H_ISSUE;
          end else begin
            s_d.req.addr = buf_addr;
            s_d.req.data = buf_data;
            s_d.left = s_q.left - 9'h001;
            s_d.st = NFC_H_BUFWAIT;
          end
        end
      end
      NFC_H_BUFWAIT: begin
        bc_cyc = '{1'b0, s_q.req.addr, s_q.req.data}; // RL5
        if (!bc_busy && !bc_done) bc_start = 1'b1;
        if (bc_done) begin
          if (s_q.left == 9'h000) begin
            s_d.st = NFC_H_CONFIRM;
          end else begin
            s_d.st = NFC_H_BUF;
            s_d.buf_ready = 1'b1;
          end
        end
      end
      NFC_H_CONFIRM: begin
        bc_cyc = '{1'b0, s_q.req.addr, nfc_pkg::D_BUF_CONFIRM}; // RL5
        if (!bc_busy && !bc_done) bc_start = 1'b1;
        if (bc_done) begin
          s_d.st = NFC_H_IDLE;
          s_d.ready = 1'b1;
        end
      end
      default: s_d.st = NFC_H_IDLE;
    endcase
  end

  nfc_bus_cycle u_cycle (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(bc_start),
    .cyc(bc_cyc),
    .busy(bc_busy),
    .done(bc_done),
    .rd_data(bc_rd),
    .dq_in_sync(s_q.dq_s2),
    .pins(pins)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: NFC_H_IDLE, req: '0, step: 5'h00, len: 5'h00,
        left: 9'h000, dq_s1: 8'h00, dq_s2: 8'h00, rd_valid: 1'b0,
        rd: 8'h00, err: 1'b0, ready: 1'b1, buf_ready: 1'b0,
        suspended: 1'b0, pins: '{addr: '0, dq_out: 8'h00, dq_oe: 1'b0,
        ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1}};
    end else begin
      s_q <= s_d;
    end
  end

  assign req_ready = s_q.ready;
  assign buf_ready = s_q.buf_ready;
  assign rd_valid = s_q.rd_valid;
  assign rd_data = s_q.rd;
  assign seq_error = s_q.err;
  assign flash_addr = s_q.pins.addr;
  assign flash_dq_out = s_q.pins.dq_out;
  assign flash_dq_oe = s_q.pins.dq_oe;
  assign flash_ce_n = s_q.pins.ce_n;
  assign flash_we_n = s_q.pins.we_n;
  assign flash_oe_n = s_q.pins.oe_n;
endmodule
`default_nettype wire

/* nfc_host_props.sv */
// Checker for the flash host pins and its request handshake.
// Bound to nfc_host; sees only its ports, one clock domain.
`default_nettype none
module nfc_host_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Handshake
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rd_valid,
  // Flash pins
  input wire logic [nfc_pkg::AW-1:0] flash_addr,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_excl;
    !(!flash_we_n && !flash_oe_n);
  endproperty
  a_excl: assert property (p_excl)
    else $error("write and read strobes low together");
  property p_wr_drive;
    !flash_we_n |-> flash_dq_oe && !flash_ce_n;
  endproperty
  a_wr_drive: assert property (p_wr_drive)
    else $error("write pulse without data drive");
  property p_rd_float;
    !flash_oe_n |-> !flash_dq_oe && !flash_ce_n;
  endproperty
  a_rd_float: assert property (p_rd_float)
    else $error("read pulse while host drives data");
  property p_we_pulse;
    $fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n;
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("write pulse length wrong");
  property p_addr_hold;
    (!flash_we_n || !flash_oe_n) |-> $stable(flash_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved inside a pulse");
  property p_rd_pulse;
    rd_valid |=> !rd_valid;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read answer longer than one cycle");
  property p_rd_after;
    $rose(flash_oe_n) |-> ##[0:8] rd_valid;
  endproperty
  a_rd_after: assert property (p_rd_after)
    else $error("read cycle gave no answer");
  property p_take;
    req_valid && req_ready |=> !req_ready;
  endproperty
  a_take: assert property (p_take)
    else $error("ready stayed high after a take");
  property p_idle;
    req_ready |-> flash_we_n && flash_oe_n;
  endproperty
  a_idle: assert property (p_idle)
    else $error("strobe active while idle");
endmodule
bind nfc_host nfc_host_props u_nfc_host_props (.core_clk(core_clk),
  .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
  .rd_valid(rd_valid), .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
  .flash_oe_n(flash_oe_n));
`default_nettype wire

/* nfc_pkg.sv */
// Package for the byte-mode NOR flash command host: codes, addresses,
// timing and the structs that carry requests and bus pins.
// Assumes a 20 MHz core clock and an asynchronous x8 flash bus.
`default_nettype none
package nfc_pkg;
  localparam int unsigned CLK_MHZ = 20;
  // Bus cycle phase lengths
  localparam int unsigned T_SETUP_NS = 50;
  localparam int unsigned T_PULSE_NS = 70;
  localparam int unsigned T_RD_NS = 100;
  function automatic logic [3:0] ns2cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c == 0) c = 1;
    return c[3:0];
  endfunction
  localparam logic [3:0] SETUP_CYC = ns2cyc(T_SETUP_NS);
  localparam logic [3:0] PULSE_CYC = ns2cyc(T_PULSE_NS);
  localparam logic [3:0] RD_CYC = ns2cyc(T_RD_NS);
  // Pin register, two input flops and one spare cycle: a read strobe is
  // stretched by this much so the sampled byte was driven under it
  localparam logic [3:0] RD_LAG_CYC = 4'h4;
  // Write buffer page is 256 bytes
  localparam int unsigned PAGE_SHIFT = 8;

  localparam int AW = 22;
  localparam logic [AW-1:0] ADDR_AAA = 22'h000AAA;
  localparam logic [AW-1:0] ADDR_555 = 22'h000555;
  localparam logic [AW-1:0] ADDR_AA = 22'h0000AA;
  localparam logic [AW-1:0] ADDR_ZERO = 22'h000000;
  localparam logic [AW-1:0] ADDR_CONT4 = 22'h5554AB;
  localparam logic [AW-1:0] ADDR_CONT5 = 22'h2AAB54;
  localparam logic [AW-1:0] ADDR_BIT_ONE = 22'h000002;

  localparam logic [7:0] D_UNLOCK1 = 8'hAA;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_SECURE_ENTRY = 8'h88;
  localparam logic [7:0] D_PROGRAM = 8'hA0;
  localparam logic [7:0] D_BUF_LOAD = 8'h25;
  localparam logic [7:0] D_BUF_CONFIRM = 8'h29;
  localparam logic [7:0] D_RESET = 8'hF0;
  localparam logic [7:0] D_RESET_ALT = 8'hFF;
  localparam logic [7:0] D_EXIT1 = 8'h90;
  localparam logic [7:0] D_ZERO = 8'h00;
  localparam logic [7:0] D_SUSPEND = 8'h51;
  localparam logic [7:0] D_RESUME = 8'h50;
  localparam logic [7:0] D_QUERY = 8'h98;
  localparam logic [7:0] D_CONT1 = 8'h71;
  localparam logic [7:0] D_CONT2 = 8'h70;
  localparam logic [7:0] D_ECC_ENTRY = 8'h75;
  localparam logic [7:0] D_AUTOSEL = 8'h90;
  localparam logic [8:0] MAX_SEQ_CYC = 9'h105;
  localparam logic [7:0] MAX_LOAD_COUNT = 8'hFF;
  localparam logic [4:0] SEQ_LEN = 5'h07;

  typedef enum logic [3:0] {
    NFC_OP_SUSPEND, NFC_OP_RESUME, NFC_OP_SECURE_ENTER, NFC_OP_SECURE_EXIT,
    NFC_OP_WORD_PROG, NFC_OP_BUF_PROG, NFC_OP_BUF_ABORT, NFC_OP_RESET,
    NFC_OP_QUERY, NFC_OP_QUERY_EXIT, NFC_OP_CONTINUITY, NFC_OP_ECC_ENTER,
    NFC_OP_READ, NFC_OP_STATUS_READ, NFC_OP_AUTOSEL_ID
  } nfc_op_t;

  typedef struct packed {
    nfc_op_t op;
    logic [AW-1:0] addr;
    logic [7:0] data;
    logic hi_half;
  } nfc_req_t;

  typedef struct packed {
    logic is_read;
    logic [AW-1:0] addr;
    logic [7:0] data;
  } nfc_cyc_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
  } nfc_pins_t;
endpackage
`default_nettype wire

/* tb_nfc_host.sv */
// Self-checking bench for nfc_host against the behavioural flash model.
// Assumes nfc_pkg and the bound checker are compiled first.
`default_nettype none
module tb_nfc_host;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [21:0] LO = 22'h000FFF;
  localparam logic [21:0] ALL = 22'h3FFFFF;
  localparam logic [21:0] NO = 22'h000000;
  localparam logic [21:0] AAA = 22'h000AAA;
  logic core_clk, rst_n, req_valid, req_ready, buf_valid, buf_ready;
  logic rd_valid, seq_error, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  nfc_pkg::nfc_req_t req;
  logic [21:0] buf_addr, flash_addr;
  logic [7:0] buf_data, rd_data, flash_dq_out, dq_rd, dq_wire, rd_last;
  logic [51:0] exp_q[$];
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int rd_n = 0;
  assign dq_wire = flash_dq_oe ? flash_dq_out : dq_rd;
  nfc_host u_nfc_host (.core_clk(core_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .buf_valid(buf_valid), .buf_addr(buf_addr), .buf_data(buf_data),
    .buf_ready(buf_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .seq_error(seq_error), .flash_addr(flash_addr), .flash_dq_in(dq_wire),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n));
  nfc_flash_model u_nfc_flash_model (.core_clk(core_clk),
    .addr(flash_addr), .dq(dq_wire), .ce_n(flash_ce_n),
    .we_n(flash_we_n), .oe_n(flash_oe_n), .dq_rd(dq_rd));
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) begin
      rd_n++;
      rd_last = rd_data;
    end
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ex(input logic [21:0] m, a, input logic [7:0] d);
    exp_q.push_back({m, a, d});
  endtask
  task automatic unl();
    ex(LO, AAA, 8'hAA);
    ex(LO, 22'h000555, 8'h55);
  endtask
  task automatic clr();
    exp_q.delete();
    u_nfc_flash_model.wr_q.delete();
  endtask
  task automatic verify();
    logic [51:0] e;
    logic [29:0] w;
    check("writes", u_nfc_flash_model.wr_q.size(), exp_q.size());
    while (exp_q.size() > 0 && u_nfc_flash_model.wr_q.size() > 0) begin
      e = exp_q.pop_front();
      w = u_nfc_flash_model.wr_q.pop_front();
      check("write addr", w[29:8] & e[51:30], e[29:8]);
      check("write data", w[7:0], e[7:0]);
    end
    clr();
  endtask
  task automatic issue(input nfc_pkg::nfc_op_t op, input logic [21:0] a,
      input logic [7:0] d, input logic h);
    int n;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= '{op, a, d, h};
    @(negedge core_clk);
    while (req_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    req_valid <= 1'b0;
    for (n = 0; n < 9000 && req_ready !== 1'b0; n++) @(negedge core_clk);
    for (n = 0; n < 9000 && req_ready !== 1'b1; n++) @(negedge core_clk);
    // Let the read monitor take the answer that ends with ready
    @(negedge core_clk);
    check("ready back", req_ready, 1'b1);
  endtask
  task automatic feed(input logic [21:0] a, input int n, bad);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      buf_valid <= 1'b1;
      buf_addr <= (i == bad) ? a + 22'h000100 : a + i;
      buf_data <= i[7:0] ^ 8'h3C;
      @(negedge core_clk);
      while (buf_ready !== 1'b1) @(negedge core_clk);
    end
    @(posedge core_clk);
    buf_valid <= 1'b0;
  endtask
  task automatic t_single();
    issue(nfc_pkg::NFC_OP_RESUME, 22'h000123, 8'h00, 1'b0);
    check("refused resume", seq_error, 1'b1);
    issue(nfc_pkg::NFC_OP_SUSPEND, 22'h012345, 8'h00, 1'b0);
    ex(NO, NO, 8'h51);
    issue(nfc_pkg::NFC_OP_RESUME, 22'h2ABCDE, 8'h00, 1'b0);
    check("resume taken", seq_error, 1'b0);
    ex(NO, NO, 8'h50);
    issue(nfc_pkg::NFC_OP_RESET, 22'h033333, 8'h00, 1'b0);
    ex(NO, NO, 8'hF0);
    issue(nfc_pkg::NFC_OP_QUERY, 22'h0000AA, 8'h00, 1'b0);
    ex(LO, 22'h0000AA, 8'h98);
    issue(nfc_pkg::NFC_OP_QUERY_EXIT, NO, 8'h00, 1'b0);
    ex(NO, NO, 8'hFF);
    verify();
  endtask
  task automatic t_secure();
    issue(nfc_pkg::NFC_OP_SECURE_ENTER, NO, 8'h00, 1'b0);
    unl();
    ex(LO, AAA, 8'h88);
    issue(nfc_pkg::NFC_OP_WORD_PROG, 22'h001234, 8'h5C, 1'b0);
    unl();
    ex(LO, AAA, 8'hA0);
    ex(ALL, 22'h001234, 8'h5C);
    issue(nfc_pkg::NFC_OP_READ, 22'h000107, 8'h00, 1'b0);
    check("secure read", rd_last, 8'hA2);
    issue(nfc_pkg::NFC_OP_SECURE_EXIT, NO, 8'h00, 1'b0);
    unl();
    ex(LO, AAA, 8'h90);
    ex(NO, NO, 8'h00);
    verify();
  endtask
  task automatic t_ecc_cont();
    int r;
    issue(nfc_pkg::NFC_OP_ECC_ENTER, NO, 8'h00, 1'b0);
    unl();
    ex(LO, AAA, 8'h75);
    issue(nfc_pkg::NFC_OP_READ, 22'h00003C, 8'h00, 1'b0);
    check("ecc read", rd_last, 8'h99);
    issue(nfc_pkg::NFC_OP_RESET, 22'h000777, 8'h00, 1'b0);
    ex(NO, NO, 8'hF0);
    verify();
    r = rd_n;
    issue(nfc_pkg::NFC_OP_CONTINUITY, NO, 8'h00, 1'b0);
    ex(LO, AAA, 8'h71);
    ex(LO, AAA, 8'h70);
    ex(ALL, 22'h5554AB, 8'hFF);
    ex(ALL, 22'h2AAB54, 8'h00);
    ex(LO, AAA, 8'h70);
    verify();
    check("cont reads", rd_n - r, 2);
    r = rd_n;
    issue(nfc_pkg::NFC_OP_AUTOSEL_ID, 22'h000002, 8'h00, 1'b0);
    unl();
    ex(LO, AAA, 8'h90);
    verify();
    check("id reads", rd_n - r, 3);
    check("id data", rd_last, 8'hA7);
  endtask
  task automatic t_status();
    for (int h = 0; h < 2; h++) begin
      issue(nfc_pkg::NFC_OP_STATUS_READ, 22'h000040, 8'h00, h[0]);
      check("half", u_nfc_flash_model.rd_addr[1], h[0]);
      check("status", rd_last, {6'h10, h[0], 1'b0} ^ 8'hA5);
      clr();
    end
  endtask
  task automatic t_buffer();
    fork
      issue(nfc_pkg::NFC_OP_BUF_PROG, 22'h012300, 8'hFF, 1'b0);
      feed(22'h012300, 256, -1);
    join
    check("buf cycles", u_nfc_flash_model.wr_q.size(), 261);
    unl();
    ex(ALL, 22'h012300, 8'h25);
    ex(ALL, 22'h012300, 8'hFF);
    for (int i = 0; i < 256; i++)
      ex(ALL, 22'h012300 + i, i[7:0] ^ 8'h3C);
    ex(ALL, 22'h0123FF, 8'h29);
    verify();
    fork
      issue(nfc_pkg::NFC_OP_BUF_PROG, 22'h012380, 8'h01, 1'b0);
      feed(22'h012380, 2, 1);
    join_any
    disable fork;
    buf_valid <= 1'b0;
    repeat (60) @(posedge core_clk);
    check("page error", seq_error, 1'b1);
    clr();
    issue(nfc_pkg::NFC_OP_BUF_ABORT, NO, 8'h00, 1'b0);
    check("error cleared", seq_error, 1'b0);
    unl();
    ex(LO, AAA, 8'hF0);
    verify();
  endtask
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    buf_valid = 1'b0;
    buf_addr = '0;
    buf_data = '0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_single();
    t_secure();
    t_ecc_cont();
    t_status();
    t_buffer();
    wrap_up();
  end
endmodule
`default_nettype wire
